/* File: core/mdc_config.sv */
// Purpose: configuration registers and pin handling of a sensorless motor controller
// Assumes: AXI4-Lite slave, aclk 125 MHz, synchronous active-low aresetn
// Notes: decoded settings leave on registered struct outputs
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module mdc_config
	import mdc_pkg::*;
#(
	parameter int PHASES = 3
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// external pins
	input wire logic brake_pin,
	input wire logic dir_pin,
	// pwm references and gate commands
	input wire logic [PHASES-1:0] pwm_ref,
	output logic [PHASES-1:0] gate_high,
	output logic [PHASES-1:0] gate_low,
	// bus current measurement, per mille of full scale
	input wire logic [9:0] bus_current_pml,
	// decoded settings
	output mdc_algo_t algo_cfg,
	output mdc_ctrl_t ctrl_out
);

	// ****************************************
	// lookup functions
	// ****************************************
	function automatic logic [15:0] accel_dhz(input logic [3:0] c);
		case (c)
			4'h0: accel_dhz = 16'h0001;
			4'h1: accel_dhz = 16'h000A;
			4'h2: accel_dhz = 16'h0014;
			4'h3: accel_dhz = 16'h001E;
			4'h4: accel_dhz = 16'h0032;
			4'h5: accel_dhz = 16'h0064;
			4'h6: accel_dhz = 16'h00C8;
			4'h7: accel_dhz = 16'h012C;
			4'h8: accel_dhz = 16'h0190;
			4'h9: accel_dhz = 16'h01F4;
			4'hA: accel_dhz = 16'h03E8;
			4'hB: accel_dhz = 16'h07D0;
			4'hC: accel_dhz = 16'h1388;
			4'hD: accel_dhz = 16'h1D4C;
			4'hE: accel_dhz = 16'h2710;
			default: accel_dhz = 16'h4E20;
		endcase
	endfunction

	function automatic logic [6:0] persist_ms(input logic [1:0] c);
		case (c)
			2'h0: persist_ms = 7'h01;
			2'h1: persist_ms = 7'h05;
			2'h2: persist_ms = 7'h32;
			default: persist_ms = 7'h64;
		endcase
	endfunction

	function automatic logic [10:0] limit_ms(input logic [1:0] c);
		case (c)
			2'h0: limit_ms = 11'h1F4;
			2'h1: limit_ms = 11'h2EE;
			2'h2: limit_ms = 11'h3E8;
			default: limit_ms = 11'h7D0;
		endcase
	endfunction

	function automatic logic [10:0] bemf_mv(input logic [2:0] c);
		case (c)
			3'h0: bemf_mv = 11'h000;
			3'h1: bemf_mv = 11'h032;
			3'h2: bemf_mv = 11'h064;
			3'h3: bemf_mv = 11'h0FA;
			3'h4: bemf_mv = 11'h1F4;
			3'h5: bemf_mv = 11'h3E8;
			3'h6: bemf_mv = 11'h4E2;
			default: bemf_mv = 11'h5DC;
		endcase
	endfunction

	function automatic logic [8:0] hold_ms(input logic [1:0] c);
		case (c)
			2'h0: hold_ms = 9'h032;
			2'h1: hold_ms = 9'h064;
			2'h2: hold_ms = 9'h0FA;
			default: hold_ms = 9'h1F4;
		endcase
	endfunction

	function automatic logic [7:0] decel_pct(input logic [2:0] c);
		case (c)
			3'h0: decel_pct = 8'h32;
			3'h1: decel_pct = 8'h3C;
			3'h2: decel_pct = 8'h46;
			3'h3: decel_pct = 8'h50;
			3'h4: decel_pct = 8'h5A;
			3'h5: decel_pct = 8'h64;
			3'h6: decel_pct = 8'h7D;
			default: decel_pct = 8'h96;
		endcase
	endfunction

	// per mille, so half-percent steps stay exact
	function automatic logic [9:0] ilim_pml(input logic [4:0] c);
		case (c)
			5'h00: ilim_pml = 10'h04B;
			5'h01: ilim_pml = 10'h050;
			5'h02: ilim_pml = 10'h055;
			5'h03: ilim_pml = 10'h05A;
			5'h04: ilim_pml = 10'h05F;
			5'h05: ilim_pml = 10'h064;
			5'h06: ilim_pml = 10'h06E;
			5'h07: ilim_pml = 10'h078;
			5'h08: ilim_pml = 10'h082;
			5'h09: ilim_pml = 10'h08C;
			5'h0A: ilim_pml = 10'h096;
			5'h0B: ilim_pml = 10'h0A0;
			5'h0C: ilim_pml = 10'h0AA;
			5'h0D: ilim_pml = 10'h0B4;
			5'h0E: ilim_pml = 10'h0C8;
			5'h0F: ilim_pml = 10'h0E1;
			5'h10: ilim_pml = 10'h0FA;
			5'h11: ilim_pml = 10'h113;
			5'h12: ilim_pml = 10'h12C;
			5'h13: ilim_pml = 10'h15E;
			5'h14: ilim_pml = 10'h190;
			5'h15: ilim_pml = 10'h1C2;
			5'h16: ilim_pml = 10'h1F4;
			5'h17: ilim_pml = 10'h226;
			5'h18: ilim_pml = 10'h258;
			5'h19: ilim_pml = 10'h2BC;
			5'h1A: ilim_pml = 10'h2EE;
			5'h1B: ilim_pml = 10'h320;
			5'h1C: ilim_pml = 10'h352;
			5'h1D: ilim_pml = 10'h384;
			5'h1E: ilim_pml = 10'h3B6;
			default: ilim_pml = 10'h3E8;
		endcase
	endfunction

	// least time, so round up to whole clocks
	function automatic logic [DEAD_CNT_W-1:0] dead_cycles(input logic [5:0] c);
		int ns;
		ns = int'(c) * DEAD_STEP_NS;
		dead_cycles = DEAD_CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = ((old & ~m) | (nw & m)) & mask;
	endfunction

	// ****************************************
	// register bus
	// ****************************************
	logic [31:0] algo_ff, pin_ff, pwr_ff;
	logic aw_got_ff, w_got_ff;
	logic [7:0] waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic do_write;

	assign awready = ~aw_got_ff & ~bvalid;
	assign wready = ~w_got_ff & ~bvalid;
	assign arready = ~rvalid;
	assign do_write = aw_got_ff & w_got_ff & ~bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			waddr_ff <= 8'h00;
		end else if (awvalid && awready) begin
			aw_got_ff <= 1'b1;
			waddr_ff <= awaddr;
		end else if (do_write) begin
			aw_got_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else if (wvalid && wready) begin
			w_got_ff <= 1'b1;
			wdata_ff <= wdata;
			wstrb_ff <= wstrb;
		end else if (do_write) begin
			w_got_ff <= 1'b0;
		end
	end

	// reserved bits never store, so they read back zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			algo_ff <= RST_ALGO;
			pin_ff <= RST_PIN;
			pwr_ff <= RST_PWR;
		end else if (do_write) begin
			case (waddr_ff)
				OFS_ALGO: algo_ff <= merge(algo_ff, wdata_ff, wstrb_ff, MASK_ALGO);
				OFS_PIN: pin_ff <= merge(pin_ff, wdata_ff, wstrb_ff, MASK_PIN);
				OFS_PWR: pwr_ff <= merge(pwr_ff, wdata_ff, wstrb_ff, MASK_PWR);
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= (waddr_ff == OFS_ALGO || waddr_ff == OFS_PIN || waddr_ff == OFS_PWR) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (araddr)
				OFS_ALGO: rdata <= algo_ff;
				OFS_PIN: rdata <= pin_ff;
				OFS_PWR: rdata <= pwr_ff;
				default: begin
					rdata <= 32'h00000000;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ****************************************
	// algorithm settings
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			algo_cfg <= '0;
		end else begin
			algo_cfg.slow_accel_dhz <= accel_dhz(algo_ff[ALGO_ACCEL_LSB +: 4]);
			algo_cfg.rotor_probe_fine_enable <= algo_ff[ALGO_PROBE_FINE_BIT];
			algo_cfg.quick_spin_detect_enable <= algo_ff[ALGO_QUICK_SPIN_BIT];
			algo_cfg.stopped_persist_ms <= persist_ms(algo_ff[ALGO_STOP_LSB +: 2]);
			algo_cfg.running_persist_ms <= persist_ms(algo_ff[ALGO_RUN_LSB +: 2]);
			algo_cfg.spin_detect_limit_ms <= limit_ms(algo_ff[ALGO_LIMIT_LSB +: 2]);
			algo_cfg.handoff_min_backemf_mv <= bemf_mv(algo_ff[ALGO_BEMF_LSB +: 3]);
			algo_cfg.brake_low_current_hold_ms <= hold_ms(algo_ff[ALGO_BRAKE_HOLD_LSB +: 2]);
			algo_cfg.reverse_decel_pct <= decel_pct(algo_ff[ALGO_DECEL_LSB +: 3]);
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] brake_sync_ff, dir_sync_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brake_sync_ff <= 2'h0;
			dir_sync_ff <= 2'h0;
		end else begin
			brake_sync_ff <= {brake_sync_ff[0], brake_pin};
			dir_sync_ff <= {dir_sync_ff[0], dir_pin};
		end
	end

	// ****************************************
	// brake, direction and current limit
	// ****************************************
	logic brake_req, nxt_ccw, ccw_ff;
	logic [1:0] brake_src, dir_src;

	assign brake_src = pin_ff[PIN_BRAKE_SRC_LSB +: 2];
	assign dir_src = pwr_ff[PWR_DIR_SRC_LSB +: 2];
	assign brake_req = (brake_src == SRC_FORCE_ON) ? 1'b1 :
		(brake_src == SRC_FORCE_OFF) ? 1'b0 : brake_sync_ff[1];
	assign nxt_ccw = (dir_src == DIR_FORCE_CCW) ? 1'b1 :
		(dir_src == DIR_FORCE_CW) ? 1'b0 : dir_sync_ff[1];

	// a flip of the effective direction, pin or override, is one change event
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ccw_ff <= 1'b0;
			ctrl_out <= '0;
		end else begin
			ccw_ff <= nxt_ccw;
			ctrl_out.supply_filter_on <= ~pin_ff[PIN_FILTER_OFF_BIT];
			ctrl_out.brake_lowside <= brake_req & ~pin_ff[PIN_BRAKE_ALIGN_BIT];
			ctrl_out.brake_align <= brake_req & pin_ff[PIN_BRAKE_ALIGN_BIT];
			ctrl_out.rotate_ccw <= nxt_ccw;
			ctrl_out.dir_change_stop <= (nxt_ccw != ccw_ff) & ~pwr_ff[PWR_DIR_MODE_BIT];
			ctrl_out.dir_change_reverse <= (nxt_ccw != ccw_ff) & pwr_ff[PWR_DIR_MODE_BIT];
			ctrl_out.current_limit_pml <= ilim_pml(pwr_ff[PWR_ILIM_LSB +: 5]);
			ctrl_out.current_limit_trip <= pwr_ff[PWR_ILIM_EN_BIT] &
				(bus_current_pml >= ilim_pml(pwr_ff[PWR_ILIM_LSB +: 5]));
		end
	end

	// ****************************************
	// dead-time insertion
	// ****************************************
	// on every edge of a phase reference both switches stay off for the dead time,
	// so an edge inside the dead time restarts it rather than shortening it
	logic [PHASES-1:0] side_ff;
	logic [DEAD_CNT_W-1:0] dead_ff [PHASES];
	logic [DEAD_CNT_W-1:0] dead_len;

	assign dead_len = dead_cycles(pwr_ff[PWR_DEAD_LSB +: 6]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			side_ff <= '0;
			gate_high <= '0;
			gate_low <= '0;
			for (int p = 0; p < PHASES; p++) begin
				dead_ff[p] <= '0;
			end
		end else begin
			for (int p = 0; p < PHASES; p++) begin
				if (pwm_ref[p] != side_ff[p]) begin
					side_ff[p] <= pwm_ref[p];
					dead_ff[p] <= dead_len;
					gate_high[p] <= 1'b0;
					gate_low[p] <= 1'b0;
				end else if (dead_ff[p] > DEAD_CNT_W'(1)) begin
					dead_ff[p] <= dead_ff[p] - DEAD_CNT_W'(1);
					gate_high[p] <= 1'b0;
					gate_low[p] <= 1'b0;
				end else begin
					dead_ff[p] <= '0;
					gate_high[p] <= side_ff[p];
					gate_low[p] <= ~side_ff[p];
				end
			end
		end
	end

endmodule // mdc_config

`default_nettype wire

/* File: core/unused_placeholder_never.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: shared/mdc_pkg.sv */
// Purpose: constants, field layout and carriers of the motor drive configuration block
// Assumes: 32-bit AXI4-Lite register words, 125 MHz system clock
// Notes: reserved bits are masked on write and read as zero
package mdc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_ALGO = 8'h5C;
	localparam logic [7:0] OFS_PIN = 8'h60;
	localparam logic [7:0] OFS_PWR = 8'h64;
	localparam logic [31:0] RST_ALGO = 32'h00000000;
	localparam logic [31:0] RST_PIN = 32'h00000000;
	localparam logic [31:0] RST_PWR = 32'h00000000;
	localparam logic [31:0] MASK_ALGO = 32'h000FFFFF;
	localparam logic [31:0] MASK_PIN = 32'h00080007;
	localparam logic [31:0] MASK_PWR = 32'h00007FFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// field positions
	// ****************************************
	localparam int ALGO_ACCEL_LSB = 16;
	localparam int ALGO_PROBE_FINE_BIT = 15;
	localparam int ALGO_QUICK_SPIN_BIT = 14;
	localparam int ALGO_STOP_LSB = 12;
	localparam int ALGO_RUN_LSB = 10;
	localparam int ALGO_LIMIT_LSB = 8;
	localparam int ALGO_BEMF_LSB = 5;
	localparam int ALGO_BRAKE_HOLD_LSB = 3;
	localparam int ALGO_DECEL_LSB = 0;
	localparam int PIN_FILTER_OFF_BIT = 19;
	localparam int PIN_BRAKE_ALIGN_BIT = 2;
	localparam int PIN_BRAKE_SRC_LSB = 0;
	localparam int PWR_DEAD_LSB = 9;
	localparam int PWR_ILIM_LSB = 4;
	localparam int PWR_ILIM_EN_BIT = 3;
	localparam int PWR_DIR_SRC_LSB = 1;
	localparam int PWR_DIR_MODE_BIT = 0;

	// ****************************************
	// override codes
	// ****************************************
	localparam logic [1:0] SRC_FORCE_ON = 2'h1;
	localparam logic [1:0] SRC_FORCE_OFF = 2'h2;
	localparam logic [1:0] DIR_FORCE_CW = 2'h1;
	localparam logic [1:0] DIR_FORCE_CCW = 2'h2;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEAD_STEP_NS = 50;
	localparam int DEAD_CNT_W = 9;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [15:0] slow_accel_dhz;
		logic rotor_probe_fine_enable;
		logic quick_spin_detect_enable;
		logic [6:0] stopped_persist_ms;
		logic [6:0] running_persist_ms;
		logic [10:0] spin_detect_limit_ms;
		logic [10:0] handoff_min_backemf_mv;
		logic [8:0] brake_low_current_hold_ms;
		logic [7:0] reverse_decel_pct;
	} mdc_algo_t;

	typedef struct packed {
		logic supply_filter_on;
		logic brake_lowside;
		logic brake_align;
		logic rotate_ccw;
		logic dir_change_stop;
		logic dir_change_reverse;
		logic current_limit_trip;
		logic [9:0] current_limit_pml;
	} mdc_ctrl_t;

endpackage

/* File: test/mdc_config_properties.sv */
// Purpose: concurrent checks on gates, decodes and direction outputs
// Assumes: one clock domain, synchronous active-low reset
// Notes: decode checks start one edge after reset release
`timescale 1ns/10ps
`default_nettype none
module mdc_config_properties
	import mdc_pkg::*;
#(
	parameter int PHASES = 3
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// gates and measurement
	input wire logic [PHASES-1:0] pwm_ref,
	input wire logic [PHASES-1:0] gate_high,
	input wire logic [PHASES-1:0] gate_low,
	input wire logic [9:0] bus_current_pml,
	// decoded settings
	input wire mdc_algo_t algo_cfg,
	input wire mdc_ctrl_t ctrl_out
);
	// ****
	// checks
	// ****
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_shoot_through: assert property ((gate_high & gate_low) == '0)
		else $error("high and low gate on together");
	chk_dead_gap: assert property ($changed(pwm_ref) |=>
		((gate_high | gate_low) & ($past(pwm_ref) ^ $past(pwm_ref, 2))) == '0)
		else $error("gate on right after reference change");
	chk_stop_persist: assert property ($past(aresetn) |->
		algo_cfg.stopped_persist_ms inside {7'h01, 7'h05, 7'h32, 7'h64})
		else $error("stopped persistence off table");
	chk_spin_limit: assert property ($past(aresetn) |->
		algo_cfg.spin_detect_limit_ms inside {11'h1F4, 11'h2EE, 11'h3E8, 11'h7D0})
		else $error("spin detect limit off table");
	chk_brake_hold: assert property ($past(aresetn) |->
		algo_cfg.brake_low_current_hold_ms inside {9'h032, 9'h064, 9'h0FA, 9'h1F4})
		else $error("brake hold off table");
	chk_decel_ratio: assert property ($past(aresetn) |-> algo_cfg.reverse_decel_pct inside
		{8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A, 8'h64, 8'h7D, 8'h96})
		else $error("decel ratio off table");
	chk_dir_pulse: assert property ((ctrl_out.dir_change_stop || ctrl_out.dir_change_reverse) |->
		$changed(ctrl_out.rotate_ccw) && !(ctrl_out.dir_change_stop && ctrl_out.dir_change_reverse))
		else $error("direction pulse without direction change");
	chk_trip_floor: assert property (ctrl_out.current_limit_trip |->
		$past(bus_current_pml) >= 10'h04B)
		else $error("trip below lowest limit");
	chk_brake_single: assert property (!(ctrl_out.brake_lowside && ctrl_out.brake_align))
		else $error("low-side and align brake together");
endmodule // mdc_config_properties
bind mdc_config mdc_config_properties #(.PHASES(PHASES)) u_mdc_config_properties (.aclk,
	.aresetn, .pwm_ref, .gate_high, .gate_low, .bus_current_pml, .algo_cfg, .ctrl_out);
`default_nettype wire

/* File: test/mdc_motor_model.sv */
// Purpose: behavioural gate driver and motor behind the gate commands
// Assumes: one clock, registered gate commands
// Notes: bus current flows only while a high side conducts
`timescale 1ns/10ps
`default_nettype none
module mdc_motor_model (
	// clock
	input wire logic aclk,
	// gate commands
	input wire logic [2:0] gate_high,
	input wire logic [2:0] gate_low,
	// load from the bench, measured current
	input wire logic [9:0] load_pml,
	output logic [9:0] bus_current_pml,
	output int shorts
);
	initial begin
		bus_current_pml = 10'h0;
		shorts = 0;
	end
	always @(posedge aclk) begin
		bus_current_pml <= (|gate_high) ? load_pml : 10'h0;
		// a shorted leg is counted, not tolerated
		if (|(gate_high & gate_low))
			shorts <= shorts + 1;
	end
endmodule // mdc_motor_model
`default_nettype wire

/* File: test/motor_drive_misc_config_tb.sv */
// Purpose: self-checking bench of the motor drive configuration block
// Assumes: axi4-lite master tasks, motor model on the gates
// Notes: bus results are queued by the drivers and checked by a monitor
`timescale 1ns/10ps
`default_nettype none
module motor_drive_misc_config_tb
	import mdc_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, brake_pin, dir_pin;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, w, lw;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] pwm_ref, gate_high, gate_low;
	logic [9:0] bus_current_pml, load_pml;
	mdc_algo_t algo_cfg;
	mdc_ctrl_t ctrl_out;
	logic [1:0] exp_b[$];
	logic [33:0] exp_r[$];
	int n_errors = 0, n_tests = 0, seed = 32'h3FF3;
	int shorts, i, k, n, nd, ns, nr, bp, fo;
	int ac[16] = '{1, 10, 20, 30, 50, 100, 200, 300, 400, 500, 1000, 2000, 5000, 7500, 10000, 20000};
	int pt[4] = '{1, 5, 50, 100};
	int tl[4] = '{500, 750, 1000, 2000};
	int bm[8] = '{0, 50, 100, 250, 500, 1000, 1250, 1500};
	int bh[4] = '{50, 100, 250, 500};
	int dc[8] = '{50, 60, 70, 80, 90, 100, 125, 150};
	int dl[4] = '{0, 1, 5, 63};
	int cl[32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150, 160, 170, 180, 200, 225,
		250, 275, 300, 350, 400, 450, 500, 550, 600, 700, 750, 800, 850, 900, 950, 1000};

	mdc_config u_mdc_config (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
		.rdata, .rresp, .brake_pin, .dir_pin, .pwm_ref, .gate_high, .gate_low, .bus_current_pml,
		.algo_cfg, .ctrl_out);
	mdc_motor_model u_mdc_motor_model (.aclk, .gate_high, .gate_low, .load_pml,
		.bus_current_pml, .shorts);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		exp_b.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		exp_r.push_back({e, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****
	// monitor of bus answers
	// ****
	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready)
			chk("bresp", exp_b.pop_front(), bresp);
		if (rvalid === 1'b1 && rready) begin
			chk("rresp", exp_r[0][33:32], rresp);
			chk("rdata", exp_r[0][31:0], rdata);
			void'(exp_r.pop_front());
		end
	end

	initial begin
		cyc(30000);
		n_errors++;
		print_verdict();
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, brake_pin, dir_pin} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		pwm_ref = 3'h0;
		load_pml = 10'h0;
		aresetn = 1'b0;
		cyc(8);
		aresetn <= 1'b1;
		rd(OFS_ALGO, RST_ALGO, RESP_OKAY);
		rd(OFS_PIN, RST_PIN, RESP_OKAY);
		rd(OFS_PWR, RST_PWR, RESP_OKAY);
		chk("filter0", 32'h1, ctrl_out.supply_filter_on);
		$display("reset values done");
		for (i = 0; i < 16; i++) begin
			w = $random(seed);
			w[19:0] = {i[3:0], i[0], i[1], i[1:0], i[3:2], i[1:0], i[2:0], i[3:2], i[2:0]};
			wr(OFS_ALGO, w, 4'hF, RESP_OKAY);
			rd(OFS_ALGO, w & MASK_ALGO, RESP_OKAY);
			chk("accel", ac[i], algo_cfg.slow_accel_dhz);
			chk("fine", i[0], algo_cfg.rotor_probe_fine_enable);
			chk("quick", i[1], algo_cfg.quick_spin_detect_enable);
			chk("stop", pt[i[1:0]], algo_cfg.stopped_persist_ms);
			chk("run", pt[i[3:2]], algo_cfg.running_persist_ms);
			chk("limit", tl[i[1:0]], algo_cfg.spin_detect_limit_ms);
			chk("bemf", bm[i[2:0]], algo_cfg.handoff_min_backemf_mv);
			chk("hold", bh[i[3:2]], algo_cfg.brake_low_current_hold_ms);
			chk("decel", dc[i[2:0]], algo_cfg.reverse_decel_pct);
		end
		lw = w & MASK_ALGO;
		wr(OFS_ALGO, 32'hFFFFFFFF, 4'h2, RESP_OKAY);
		rd(OFS_ALGO, lw | 32'h0000FF00, RESP_OKAY);
		wr(8'h68, w, 4'hF, RESP_SLVERR);
		rd(8'h68, 32'h0, RESP_SLVERR);
		$display("algorithm word done");
		for (i = 0; i < 8; i++) begin
			bp = $random(seed);
			fo = $random(seed);
			brake_pin <= bp[0];
			w = $random(seed);
			w[19] = fo[0];
			w[2:0] = i[2:0];
			wr(OFS_PIN, w, 4'hF, RESP_OKAY);
			cyc(4);
			rd(OFS_PIN, w & MASK_PIN, RESP_OKAY);
			k = (i[1:0] == 2'h1) || (i[0] == i[1] && bp[0]);
			chk("filter", !fo[0], ctrl_out.supply_filter_on);
			chk("lowside", k && !i[2], ctrl_out.brake_lowside);
			chk("align", k && i[2], ctrl_out.brake_align);
		end
		$display("pin word done");
		foreach (dl[j]) begin
			wr(OFS_PWR, dl[j] << 9, 4'hF, RESP_OKAY);
			pwm_ref <= 3'h0;
			cyc(420);
			// all legs switch together, so every phase sees the same dead time
			pwm_ref <= 3'h7;
			n = 0;
			for (k = 0; k < 450 && gate_high[0] !== 1'b1; k++) begin
				cyc(1);
				n += (gate_high[0] === 1'b0 && gate_low[0] === 1'b0);
			end
			nd = dl[j] ? (50 * dl[j] + 7) / 8 : 1;
			chk("dead", nd, n);
			chk("gates_high", 32'h7, gate_high);
			chk("gates_low", 32'h0, gate_low);
		end
		$display("dead time done");
		for (i = 0; i < 32; i++) begin
			fo = $random(seed);
			wr(OFS_PWR, (i << 4) | (fo[0] << 3), 4'hF, RESP_OKAY);
			load_pml <= 10'(cl[i] - fo[1]);
			cyc(4);
			chk("ilim", cl[i], ctrl_out.current_limit_pml);
			chk("trip", fo[0] && !fo[1], ctrl_out.current_limit_trip);
		end
		$display("current limit done");
		for (i = 0; i < 8; i++) begin
			dir_pin <= 1'b0;
			wr(OFS_PWR, i[2:0], 4'hF, RESP_OKAY);
			cyc(6);
			dir_pin <= 1'b1;
			ns = 0;
			nr = 0;
			repeat (6) begin
				cyc(1);
				ns += ctrl_out.dir_change_stop;
				nr += ctrl_out.dir_change_reverse;
			end
			k = i[2:1] == 2'h0 || i[2:1] == 2'h3;
			chk("ccw", i[2:1] == 2'h2 || k, ctrl_out.rotate_ccw);
			chk("stops", k && !i[0], ns);
			chk("reverses", k && i[0], nr);
		end
		chk("shorts", 32'h0, shorts);
		$display("power word done");
		print_verdict();
	end
endmodule // motor_drive_misc_config_tb
`default_nettype wire
